//--- core/dram_mode_controller.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// APB-driven issuer of mode register and self-refresh commands
module dram_mode_controller
   import dram_mode_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   dram_cmd_if.controller   bus
);
   logic [3:0]  op_ff;
   logic [17:0] arg_ff;
   logic        busy_ff;
   logic [7:0]  wait_ff;
   logic [7:0]  rd_ff;
   logic        go;
   logic        cs_ff, ras_ff, cas_ff, we_ff, cke_ff;
   logic [2:0]  bank_ff;
   logic [14:0] addr_ff;
   logic        mpr_on_ff;
   logic        wl_ff;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(paddr == OFF_CMD || paddr == OFF_ADDR
                                         || paddr == OFF_STATUS || paddr == OFF_RDDATA);
   assign go = psel && penable && pwrite && paddr == OFF_CMD && !busy_ff;
   assign prdata = (paddr == OFF_STATUS) ? {30'h0, mpr_on_ff, busy_ff}
                 : (paddr == OFF_RDDATA) ? {24'h0, rd_ff}
                 : (paddr == OFF_ADDR) ? {14'h0, arg_ff} : 32'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         arg_ff <= 18'h0;
      else if (psel && penable && pwrite && paddr == OFF_ADDR)
         arg_ff <= pwdata[17:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_ff <= 1'b0; wait_ff <= 8'h0; op_ff <= 4'h0; mpr_on_ff <= 1'b0;
         wl_ff <= 1'b0;
         {cs_ff, ras_ff, cas_ff, we_ff} <= 4'hf; cke_ff <= 1'b1;
         bank_ff <= 3'h0; addr_ff <= 15'h0;
      end
      else if (go)
      begin
         busy_ff <= 1'b1;
         op_ff   <= pwdata[3:0];
         bank_ff <= arg_ff[17:15];
         wait_ff <= 8'(TMOD_CYC);
         case (pwdata[3:0])
            op_mrs:
            begin
               {cs_ff, ras_ff, cas_ff, we_ff} <= CMD_MRS;
               // reserved bits forced low, termination bits 10:9 passed through
               if (arg_ff[17:15] == BANK_MR2)
                  addr_ff <= arg_ff[14:0] & 15'h06ff;
               else if (arg_ff[17:15] == BANK_MR3)
               begin
                  addr_ff   <= arg_ff[14:0] & 15'h0007;
                  mpr_on_ff <= arg_ff[2];
               end
               else
                  addr_ff <= arg_ff[14:0];
               // leveling state follows first register bit 7
               if (arg_ff[17:15] == BANK_MR1)
                  wl_ff <= arg_ff[7];
               if (arg_ff[17:15] == BANK_MR2 || arg_ff[17:15] == BANK_MR3)
                  bank_ff <= arg_ff[17:15];
            end
            op_dloff:
            begin
               // odt stays low; dynamic termination cleared first
               {cs_ff, ras_ff, cas_ff, we_ff} <= CMD_MRS;
               bank_ff <= BANK_MR2;
               addr_ff <= {arg_ff[14:11], 2'h0, arg_ff[8:0]} & 15'h00ff;
               // two mode sets, each followed by a full tMOD gap
               wait_ff <= 8'(2 * TMOD_CYC);
            end
            op_read:
            begin
               {cs_ff, ras_ff, cas_ff, we_ff} <= CMD_READ;
               wait_ff <= 8'h10;
            end
            op_sre:
            begin
               if (!mpr_on_ff)
               begin
                  {cs_ff, ras_ff, cas_ff, we_ff} <= CMD_SRE;
                  cke_ff <= 1'b0;
               end
               wait_ff <= 8'(TCKSRE_CYC);
            end
            op_srx:
            begin
               cke_ff  <= 1'b1;
               wait_ff <= 8'(TCKSRX_CYC + TXS_CYC + TMOD_CYC);
            end
            default: wait_ff <= 8'h1;
         endcase
      end
      else if (busy_ff)
      begin
         {cs_ff, ras_ff, cas_ff, we_ff} <= 4'hf;
         if (op_ff == op_dloff && wait_ff == 8'(TMOD_CYC + 1))
         begin
            {cs_ff, ras_ff, cas_ff, we_ff} <= CMD_MRS;
            bank_ff <= BANK_MR1;
            addr_ff <= 15'h0001;
         end
         wait_ff <= wait_ff - 8'h1;
         if (wait_ff == 8'h1)
            busy_ff <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_ff <= 8'h0;
      else if (bus.dq_valid)
         rd_ff <= bus.dq;
   end

   assign bus.cs_n = cs_ff;
   assign bus.ras_n = ras_ff;
   assign bus.cas_n = cas_ff;
   assign bus.we_n = we_ff;
   assign bus.bank = bank_ff;
   assign bus.addr = addr_ff;
   assign bus.cke = cke_ff;
   assign bus.odt = 1'b0;
   assign bus.write_leveling = wl_ff;
endmodule : dram_mode_controller

//--- core/dram_mode_pkg.sv
// Function
// - MRS with bank 010 writes second register
// - controller zeroes reserved bits of second register
// - partial refresh loses data outside range
// - bits 5:3 set write command latency
// - write latency is added delay plus latency
// - auto refresh rate overrides temp select
// - controller issues self refresh without setting temp select
// - bits 10:9 select dynamic write termination
// - no dynamic termination during write leveling
// - MRS with bank 011 writes third register
// - controller zeroes reserved bits of third register
// - bit 2 enables pattern; else 1:0 ignored
// - banks idle before enabling calibration pattern
// - reads return pattern while pattern enabled
// - only reads while pattern enabled, reset allowed; controller refuses only self refresh entry then
// - NOP registers nothing, work continues
// - deselect ignores bus, work continues
// - first register bit 0 turns DLL off
// - DLL off supports only latencies six
// - DLL off strobe timing one cycle earlier
// - controller follows DLL on-to-off sequence
// - after exit hold CKE high, ODT low
// - controller zeroes dynamic termination for DLL off
package dram_mode_pkg;
   localparam int ADDR_W = 15;
   localparam logic [2:0] BANK_MR1 = 3'h1;
   localparam logic [2:0] BANK_MR2 = 3'h2;
   localparam logic [2:0] BANK_MR3 = 3'h3;
   localparam logic [ADDR_W-1:0] MR2_RESET = 15'h0000;
   localparam logic [ADDR_W-1:0] MR3_RESET = 15'h0000;
   localparam logic [2:0] CWL_BASE = 3'h5;
   localparam logic [3:0] DLL_OFF_LAT = 4'h6;
   localparam logic [7:0] CAL_PATTERN = 8'h55;
   localparam logic [31:0] OFF_CMD = 32'h00;
   localparam logic [31:0] OFF_ADDR = 32'h04;
   localparam logic [31:0] OFF_STATUS = 32'h08;
   localparam logic [31:0] OFF_RDDATA = 32'h0c;
   localparam int TMOD_CYC = 12;
   localparam int TXS_CYC = 8;
   localparam int TCKSRE_CYC = 5;
   localparam int TCKSRX_CYC = 5;
   typedef enum logic [3:0]
   {
      op_nop   = 4'h0,
      op_mrs   = 4'h1,
      op_read  = 4'h2,
      op_sre   = 4'h3,
      op_srx   = 4'h4,
      op_dloff = 4'h5
   } op_e;
   function automatic logic [3:0] cmd_code(input logic cs_n, input logic ras_n, input logic cas_n, input logic we_n);
      cmd_code = {cs_n, ras_n, cas_n, we_n};
   endfunction : cmd_code
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_SRE = 4'h1;
   localparam logic [3:0] CMD_NOP = 4'h7;
endpackage : dram_mode_pkg

//--- core/dram_cmd_if.sv
`timescale 1ns/1ps
interface dram_cmd_if;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [2:0]  bank;
   logic [14:0] addr;
   logic        cke;
   logic        odt;
   logic        write_leveling;
   logic [7:0]  dq;
   logic        dq_valid;
   logic        dq_oe;
   modport device (input cs_n, ras_n, cas_n, we_n, bank, addr, cke, odt, write_leveling,
                   output dq, dq_valid, dq_oe);
   modport controller (output cs_n, ras_n, cas_n, we_n, bank, addr, cke, odt, write_leveling,
                       input dq, dq_valid, dq_oe);
endinterface : dram_cmd_if

//--- core/latency_delay.sv
`timescale 1ns/1ps
// shift delay of a strobe by a run-time count of cycles
module latency_delay
   import dram_mode_pkg::*;
#(
   parameter int DEPTH = 16
)
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       in_pulse,
   input  wire logic [3:0] delay,
   output logic            out_pulse
);
   logic [DEPTH-1:0] pipe_ff;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pipe_ff <= '0;
      else
         pipe_ff <= {pipe_ff[DEPTH-2:0], in_pulse};
   end
   // delay zero is treated as one cycle
   always_comb
   begin
      out_pulse = (delay == 4'h0) ? pipe_ff[0] : pipe_ff[delay - 4'h1];
   end
endmodule : latency_delay

//--- core/dram_mode_device.sv
`timescale 1ns/1ps
module dram_mode_device
   import dram_mode_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   dram_cmd_if.device       bus,
   input  wire logic        high_temp,
   output logic [14:0]      refresh_and_write_latency_mode_ff,
   output logic [14:0]      calibration_pattern_mode_ff,
   output logic             dll_off_ff,
   output logic             self_refresh_ff,
   output logic             partial_refresh_loss_ff,
   output logic             fast_refresh_rate_ff,
   output logic [1:0]       write_termination_ff,
   output logic [3:0]       write_latency_ff,
   output logic [3:0]       read_strobe_delay_ff
);
   logic [3:0]  cmd;
   logic        sel;
   logic        sre;
   logic        rd_start;
   logic        rd_out;
   logic [3:0]  nxt_rd_delay;
   logic [7:0]  dq_ff;
   logic        dq_valid_ff;
   logic [3:0]  added_delay_ff;
   logic [3:0]  read_latency_ff;

   // deselected cycles decode to nothing, pending reads still drain
   assign cmd = cmd_code(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n);
   assign sel = !bus.cs_n && bus.cke && (cmd != CMD_NOP);
   // self refresh entry is registered with cke already low
   assign sre = !bus.cs_n && !bus.cke && (cmd == CMD_SRE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         refresh_and_write_latency_mode_ff <= MR2_RESET;
         calibration_pattern_mode_ff       <= MR3_RESET;
         dll_off_ff                        <= 1'b0;
      end
      else if (sel && cmd == CMD_MRS)
      begin
         if (bus.bank == BANK_MR2)
            refresh_and_write_latency_mode_ff <= bus.addr;
         if (bus.bank == BANK_MR3)
            calibration_pattern_mode_ff <= bus.addr;
         if (bus.bank == BANK_MR1)
            dll_off_ff <= bus.addr[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         self_refresh_ff <= 1'b0;
      else if (sre)
         self_refresh_ff <= 1'b1;
      else if (self_refresh_ff && bus.cke && bus.cs_n)
         self_refresh_ff <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         partial_refresh_loss_ff <= 1'b0;
         fast_refresh_rate_ff    <= 1'b0;
         write_termination_ff    <= 2'h0;
         write_latency_ff        <= 4'h0;
         added_delay_ff          <= 4'h0;
         read_latency_ff         <= DLL_OFF_LAT;
      end
      else
      begin
         // loss only flagged once self refresh is entered
         partial_refresh_loss_ff <= self_refresh_ff && (refresh_and_write_latency_mode_ff[2:0] != 3'h0);
         fast_refresh_rate_ff    <= refresh_and_write_latency_mode_ff[6] ? high_temp
                                    : refresh_and_write_latency_mode_ff[7];
         write_termination_ff    <= (bus.write_leveling || dll_off_ff) ? 2'h0
                                    : refresh_and_write_latency_mode_ff[10:9];
         write_latency_ff        <= added_delay_ff + (dll_off_ff ? DLL_OFF_LAT
                                    : {1'b0, refresh_and_write_latency_mode_ff[5:3]} + {1'b0, CWL_BASE});
         added_delay_ff          <= 4'h0;
         read_latency_ff         <= DLL_OFF_LAT;
      end
   end

   // dll off moves the strobe reference one cycle earlier
   assign nxt_rd_delay = added_delay_ff + read_latency_ff - {3'h0, dll_off_ff};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         read_strobe_delay_ff <= 4'h0;
      else
         read_strobe_delay_ff <= nxt_rd_delay;
   end

   assign rd_start = sel && cmd == CMD_READ;
   latency_delay #(.DEPTH(16)) u_rd_delay
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_pulse  (rd_start),
      .delay     (nxt_rd_delay),
      .out_pulse (rd_out)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dq_ff       <= 8'h00;
         dq_valid_ff <= 1'b0;
      end
      else
      begin
         dq_valid_ff <= rd_out;
         // A1:A0 are never used; bit 2 alone selects the pattern
         dq_ff <= !rd_out ? 8'h00 : calibration_pattern_mode_ff[2] ? CAL_PATTERN : 8'h00;
      end
   end
   assign bus.dq       = dq_ff;
   assign bus.dq_valid = dq_valid_ff;
   assign bus.dq_oe    = dq_valid_ff;
endmodule : dram_mode_device

//--- bench/dram_mode_monitor.sv
`timescale 1ns/1ps
module dram_mode_monitor
   import dram_mode_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [2:0]  bank,
   input wire logic [14:0] addr,
   input wire logic        cke,
   input wire logic        odt,
   input wire logic [7:0]  dq,
   input wire logic        dq_valid
);
   logic [3:0] cmd;
   logic       pat_ff;
   assign cmd = cmd_code(cs_n, ras_n, cas_n, we_n);
   // own copy of the pattern bit, so a stuck device register is still caught
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pat_ff <= 1'b0;
      else if (cmd == CMD_MRS && bank == BANK_MR3)
         pat_ff <= addr[2];
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_CMD_ONE_CYCLE: assert property (!cs_n |=> cs_n)
      else $error("command pins held past one cycle");
   AST_MR2_RSVD: assert property (cmd == CMD_MRS && bank == BANK_MR2 |-> !addr[8] && addr[14:11] == 4'h0)
      else $error("reserved bits set in second register write");
   AST_MR3_RSVD: assert property (cmd == CMD_MRS && bank == BANK_MR3 |-> addr[14:3] == 12'h000)
      else $error("reserved bits set in third register write");
   AST_MRS_SPACING: assert property (cmd == CMD_MRS |=> cs_n [*8])
      else $error("command issued inside mode set wait");
   AST_READ_DATA: assert property (cmd == CMD_READ |-> ##[1:24] dq_valid)
      else $error("read produced no data");
   AST_DQ_PULSE: assert property ($rose(dq_valid) |=> !dq_valid)
      else $error("read data valid longer than one cycle");
   AST_PATTERN_DATA: assert property (dq_valid && pat_ff |-> dq == CAL_PATTERN)
      else $error("read data not calibration pattern");
   AST_SRE_REFUSED: assert property (cmd == CMD_SRE |-> !pat_ff)
      else $error("self refresh issued while pattern on");
   AST_SRX_HOLD: assert property ($rose(cke) |-> (cke && !odt) [*8])
      else $error("cke or odt moved after self refresh exit");
   C_PATTERN: cover property (cmd == CMD_MRS && bank == BANK_MR3 && addr[2]);
   C_READ: cover property (dq_valid);
   C_SRX: cover property ($rose(cke));
endmodule : dram_mode_monitor

//--- bench/dram_mode_reg_dll_off_ctrl_tb_top.sv
`timescale 1ns/1ps
module dram_mode_reg_dll_off_ctrl_tb_top
   import dram_mode_pkg::*;
();
   // ht drives the thermal sensor input, fr is the expected refresh rate
   typedef struct packed {logic [14:0] a; logic ht; logic [3:0] wl; logic [1:0] wt; logic fr;} row_s;
   row_s        rows [7] = '{'{15'h0000, 1'b1, 4'h5, 2'h0, 1'b0}, '{15'h0618, 1'b1, 4'h8, 2'h3, 1'b0},
                             '{15'h02a8, 1'b1, 4'ha, 2'h1, 1'b1}, '{15'h0490, 1'b1, 4'h7, 2'h2, 1'b1},
                             '{15'h0038, 1'b1, 4'hc, 2'h0, 1'b0}, '{15'h00c0, 1'b0, 4'h5, 2'h0, 1'b0},
                             '{15'h0040, 1'b1, 4'h5, 2'h0, 1'b1}};
   logic        pclk, presetn, psel, penable, pwrite, high_temp, pready, pslverr, er;
   logic        dll_off, self_ref, fast, loss;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [14:0] mr2, mr3;
   logic [1:0]  wterm;
   logic [3:0]  wlat, rdel;
   int          fail_count, tests_run;
   dram_cmd_if bus ();
   dram_mode_controller u_dram_mode_controller (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .bus(bus.controller));
   dram_mode_device u_dram_mode_device (.pclk, .presetn, .bus(bus.device), .high_temp,
      .refresh_and_write_latency_mode_ff(mr2), .calibration_pattern_mode_ff(mr3), .dll_off_ff(dll_off),
      .self_refresh_ff(self_ref), .partial_refresh_loss_ff(loss), .fast_refresh_rate_ff(fast),
      .write_termination_ff(wterm), .write_latency_ff(wlat), .read_strobe_delay_ff(rdel));
   dram_mode_monitor u_dram_mode_monitor (.pclk, .presetn, .cs_n(bus.cs_n), .ras_n(bus.ras_n),
      .cas_n(bus.cas_n), .we_n(bus.we_n), .bank(bus.bank), .addr(bus.addr), .cke(bus.cke), .odt(bus.odt),
      .dq(bus.dq), .dq_valid(bus.dq_valid));
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   // leading edge keeps one idle cycle, so psel is never assigned twice in a step
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; pready !== 1'b1 && n < 50; n++)
         @(posedge pclk);
      if (n == 50)
         fail_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic op(input op_e code, input logic [2:0] b, input logic [14:0] a);
      int n;
      apb(1'b1, OFF_ADDR, {14'h0, b, a});
      apb(1'b1, OFF_CMD, {28'h0, code});
      rd = 32'h1;
      for (n = 0; rd[0] !== 1'b0 && n < 100; n++)
         apb(1'b0, OFF_STATUS, 32'h0);
      if (n == 100)
         fail_count++;
   endtask : op
   task summarize;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      summarize();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      high_temp = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk(mr2, MR2_RESET);
      foreach (rows[i])
      begin
         high_temp <= rows[i].ht;
         op(op_mrs, BANK_MR2, rows[i].a);
         chk(mr2, rows[i].a);
         chk(wlat, rows[i].wl);
         chk(wterm, rows[i].wt);
         chk(fast, rows[i].fr);
         $display("row %0d done", i);
      end
      // second order lands inside the first one's wait and must be dropped
      apb(1'b1, OFF_ADDR, {14'h0, BANK_MR2, 15'h0000});
      apb(1'b1, OFF_CMD, {28'h0, op_mrs});
      op(op_mrs, BANK_MR2, 15'h0618);
      chk(mr2, 15'h0000);
      chk(rdel, DLL_OFF_LAT);
      $display("busy refusal done");
      op(op_mrs, BANK_MR3, 15'h0004);
      chk(mr3, 15'h0004);
      chk(rd[1], 1'b1);
      op(op_read, 3'h0, 15'h0000);
      apb(1'b0, OFF_RDDATA, 32'h0);
      chk(rd[7:0], CAL_PATTERN);
      op(op_sre, 3'h0, 15'h0000);
      chk(self_ref, 1'b0);
      op(op_mrs, BANK_MR3, 15'h0003);
      chk(rd[1], 1'b0);
      chk(mr2, 15'h0000);
      $display("pattern done");
      op(op_dloff, BANK_MR1, 15'h0081);
      chk(dll_off, 1'b1);
      chk(fast, 1'b1);
      chk(wlat, DLL_OFF_LAT);
      chk(rdel, DLL_OFF_LAT - 4'h1);
      op(op_sre, 3'h0, 15'h0000);
      chk(self_ref, 1'b1);
      chk(loss, 1'b1);
      op(op_srx, 3'h0, 15'h0000);
      chk(self_ref, 1'b0);
      chk(loss, 1'b0);
      apb(1'b0, 32'h10, 32'h0);
      chk(er, 1'b1);
      $display("dll off done");
      presetn <= 1'b0;
      @(posedge pclk);
      chk(mr3, MR3_RESET);
      chk(dll_off, 1'b0);
      $display("reset done");
      presetn <= 1'b1;
      op(op_mrs, BANK_MR2, 15'h0618);
      chk(mr2, 15'h0618);
      chk(wterm, 2'h3);
      op(op_mrs, BANK_MR1, 15'h0080);
      chk(wterm, 2'h0);
      chk(dll_off, 1'b0);
      op(op_mrs, BANK_MR1, 15'h0000);
      chk(wterm, 2'h3);
      $display("leveling done");
      summarize();
   end
endmodule : dram_mode_reg_dll_off_ctrl_tb_top
